// ---- rtl/hbgmc_cfg.svh ----
// Register map, field positions, reset values and timing counts of the bridge gate control.
`ifndef HBGMC_CFG_SVH
`define HBGMC_CFG_SVH
`define HBGMC_ADDR_SRC_SEL      2'h0
`define HBGMC_ADDR_LVL_CTL      2'h1
`define HBGMC_ADDR_STATUS       2'h2
`define HBGMC_BIT_GATE1         3
`define HBGMC_BIT_RSV2          2
`define HBGMC_BIT_GATE0         1
`define HBGMC_BIT_RSV0          0
`define HBGMC_RST_SRC_SEL       8'h00
`define HBGMC_RST_LVL_CTL       8'h00
`define HBGMC_IMPL_MASK         8'h0F
`define HBGMC_SLEEP_TIME_US     10000
`define HBGMC_CLK_MHZ           25
`define HBGMC_SLEEP_CYCLES      ((`HBGMC_SLEEP_TIME_US * `HBGMC_CLK_MHZ) + 1)
`endif

// ---- rtl/hbgmc_pkg.sv ----
// Types shared by the bridge gate control.
package hbgmc_pkg;
    typedef enum logic [1:0] {
        HBGMC_STANDBY = 2'b00,
        HBGMC_REVERSE = 2'b01,
        HBGMC_FORWARD = 2'b10,
        HBGMC_BRAKE   = 2'b11
    } hbgmc_mode_t;
    typedef enum logic [0:0] {
        HBGMC_ACTIVE = 1'b0,
        HBGMC_SLEEP  = 1'b1
    } hbgmc_period_t;
endpackage

// ---- rtl/hbgmc_top.sv ----
// Gate source selection, bridge mode decode and sleep period control.
//
// Contract
// - Gate 1 follows the periodic timer output when its select bit is 0, else its level bit.
// - Gate 0 follows the timer PWM when its select bit is 0, else its level bit.
// - Under software control gate 1 is low for level bit 0 and high for level bit 1.
// - Under software control gate 0 is low for level bit 0 and high for level bit 1.
// - Bits 7 to 4 of both control registers read as zero.
// - Active inputs 00 give standby with floating outputs, 01 give reverse (A low, B high).
// - Asleep, inputs 00 still give standby and inputs 11 still give brake.
// - Standby or brake held more than 10 ms enters sleep, which powers internal blocks down.
// - Asleep, moving between brake and standby changes only the outputs and sleep holds.
// - Forward or reverse returns the driver to the active period.
// - Asleep, standby and brake outputs are not protected.
// - In the active period the current, short and temperature guards protect the bridge.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "hbgmc_cfg.svh"
module hbgmc_top import hbgmc_pkg::*; #(
    parameter int unsigned SLEEP_CYCLES = `HBGMC_SLEEP_CYCLES
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // Register port
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Timer sources
    input  wire logic       timer_pwm,
    input  wire logic       periodic_timer_output,
    // Protection fault levels
    input  wire logic       over_current_guard,
    input  wire logic       short_circuit_guard,
    input  wire logic       over_temp_guard,
    // Gates and bridge
    output logic            gate_out_0,
    output logic            gate_out_1,
    output logic            bridge_out_a,
    output logic            bridge_out_a_oe,
    output logic            bridge_out_b,
    output logic            bridge_out_b_oe,
    output logic            high_switch_a,
    output logic            low_switch_a,
    output logic            high_switch_b,
    output logic            low_switch_b,
    output logic            sleep_period,
    output logic            protect_trip
);

    localparam int unsigned CW = $clog2(SLEEP_CYCLES + 1);

    typedef struct packed {
        logic [7:0]    src_sel;
        logic [7:0]    lvl_ctl;
        logic [7:0]    rdata;
        logic          gate0;
        logic          gate1;
        hbgmc_mode_t   mode;
        hbgmc_period_t period;
        logic [CW-1:0] idle_cnt;
        logic          trip;
    } hbgmc_state_t;

    hbgmc_state_t s_q;
    hbgmc_state_t s_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One select bit chooses the timer source or the software level.
    function automatic logic gate_pick(input logic sel, input logic tmr, input logic lvl);
        return sel ? lvl : tmr;
    endfunction

    function automatic logic mode_idle(input hbgmc_mode_t m);
        return (m == HBGMC_STANDBY) || (m == HBGMC_BRAKE);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic fault;
        fault = over_current_guard | short_circuit_guard | over_temp_guard;
        s_d = s_q;
        s_d.rdata = 8'h00;
        // Writes keep only the low nibble; reserved bits store what software wrote.
        if (reg_wr && reg_addr == `HBGMC_ADDR_SRC_SEL) begin
            s_d.src_sel = reg_wdata & `HBGMC_IMPL_MASK;
        end
        if (reg_wr && reg_addr == `HBGMC_ADDR_LVL_CTL) begin
            s_d.lvl_ctl = reg_wdata & `HBGMC_IMPL_MASK;
        end
        if (reg_rd) begin
            case (reg_addr)
                `HBGMC_ADDR_SRC_SEL: s_d.rdata = s_q.src_sel;
                `HBGMC_ADDR_LVL_CTL: s_d.rdata = s_q.lvl_ctl;
                `HBGMC_ADDR_STATUS:  s_d.rdata = {5'h00, s_q.trip, s_q.mode == HBGMC_BRAKE,
                                                  s_q.period == HBGMC_SLEEP};
                default:             s_d.rdata = 8'h00;
            endcase
        end
        s_d.gate0 = gate_pick(s_q.src_sel[`HBGMC_BIT_GATE0], timer_pwm,
                              s_q.lvl_ctl[`HBGMC_BIT_GATE0]);
        s_d.gate1 = gate_pick(s_q.src_sel[`HBGMC_BIT_GATE1], periodic_timer_output,
                              s_q.lvl_ctl[`HBGMC_BIT_GATE1]);
        s_d.mode = hbgmc_mode_t'({s_q.gate0, s_q.gate1});
        // The idle count restarts whenever the mode changes, so the hold is continuous.
        if (!mode_idle(s_q.mode) || s_q.mode != s_d.mode) begin
            s_d.idle_cnt = '0;
        end else if (s_q.idle_cnt != CW'(SLEEP_CYCLES)) begin
            s_d.idle_cnt = s_q.idle_cnt + CW'(1);
        end
        case (s_q.period)
            HBGMC_ACTIVE: begin
                if (s_q.idle_cnt == CW'(SLEEP_CYCLES) && mode_idle(s_d.mode)) begin
                    s_d.period = HBGMC_SLEEP;
                end
            end
            HBGMC_SLEEP: begin
                if (!mode_idle(s_d.mode)) begin
                    s_d.period = HBGMC_ACTIVE;
                end
            end
            default: s_d.period = HBGMC_ACTIVE;
        endcase
        // Guards are powered down while asleep, so the trip follows a fault only when active.
        if (s_q.period == HBGMC_SLEEP) begin
            s_d.trip = 1'b0;
        end else begin
            s_d.trip = fault;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '{src_sel: `HBGMC_RST_SRC_SEL, lvl_ctl: `HBGMC_RST_LVL_CTL, rdata: 8'h00,
                     gate0: 1'b0, gate1: 1'b0, mode: HBGMC_STANDBY, period: HBGMC_ACTIVE,
                     idle_cnt: '0, trip: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Bridge decode
    // ------------------------------------------------------------
    always_comb begin
        high_switch_a = 1'b0;
        low_switch_a  = 1'b0;
        high_switch_b = 1'b0;
        low_switch_b  = 1'b0;
        if (!s_q.trip) begin
            case (s_q.mode)
                HBGMC_REVERSE: begin
                    low_switch_a  = 1'b1;
                    high_switch_b = 1'b1;
                end
                HBGMC_FORWARD: begin
                    high_switch_a = 1'b1;
                    low_switch_b  = 1'b1;
                end
                HBGMC_BRAKE: begin
                    low_switch_a = 1'b1;
                    low_switch_b = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    assign bridge_out_a    = high_switch_a;
    assign bridge_out_b    = high_switch_b;
    assign bridge_out_a_oe = high_switch_a | low_switch_a;
    assign bridge_out_b_oe = high_switch_b | low_switch_b;
    assign gate_out_0      = s_q.gate0;
    assign gate_out_1      = s_q.gate1;
    assign sleep_period    = s_q.period == HBGMC_SLEEP;
    assign protect_trip    = s_q.trip;
    assign reg_rdata       = s_q.rdata;

endmodule // hbgmc_top
`default_nettype wire

// ---- verification/hbgmc_motor.sv ----
// Brushed motor across the bridge; a stalled rotor raises the current fault.
`timescale 1ns/1ns
`default_nettype none
module hbgmc_motor (
    // Bridge switches
    input  wire logic high_switch_a,
    input  wire logic low_switch_a,
    input  wire logic high_switch_b,
    input  wire logic low_switch_b,
    // Load state and fault
    input  wire logic stall,
    output logic      over_current_guard
);
    // Current flows only on a diagonal path, so brake and standby never trip.
    assign over_current_guard = stall & ((high_switch_a & low_switch_b)
                                         | (high_switch_b & low_switch_a));
endmodule // hbgmc_motor
`default_nettype wire

// ---- verification/hbgmc_sva.sv ----
// Port checker of the bridge gate control.
`timescale 1ns/1ns
`default_nettype none
module hbgmc_sva (
    input wire logic       sys_clk, rst_n, reg_rd, over_current_guard,
    input wire logic [7:0] reg_rdata,
    input wire logic       short_circuit_guard, over_temp_guard, gate_out_0, gate_out_1,
    input wire logic       bridge_out_a_oe, bridge_out_a, bridge_out_b_oe, bridge_out_b,
    input wire logic       high_switch_a, low_switch_a, high_switch_b, low_switch_b,
    input wire logic       sleep_period, protect_trip
);
    wire logic [1:0] g = {gate_out_0, gate_out_1};
    wire logic [7:0] o = {bridge_out_a_oe, bridge_out_a, bridge_out_b_oe, bridge_out_b,
                          high_switch_a, low_switch_a, high_switch_b, low_switch_b};
    wire logic f = over_current_guard | short_circuit_guard | over_temp_guard;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_wake; sleep_period && g[1] != g[0]; endsequence
    a_stby_float: assert property ($past(g) == 2'h0 |-> !o[7] && !o[5] && o[3:0] == 4'h0)
        else $error("standby drives");
    a_rev_drive: assert property ($past(g) == 2'h1 && !protect_trip |-> o == 8'hB6)
        else $error("bad reverse");
    a_fwd_drive: assert property ($past(g) == 2'h2 && !protect_trip |-> o == 8'hE9)
        else $error("bad forward");
    a_brake_low: assert property ($past(g) == 2'h3 && !protect_trip |-> o == 8'hA5)
        else $error("bad brake");
    a_trip_follow: assert property ($past(rst_n) && !$past(sleep_period) && !sleep_period
        |-> protect_trip == $past(f) && (!protect_trip || o[3:0] == 4'h0))
        else $error("bad trip");
    a_sleep_bare: assert property (sleep_period |-> !protect_trip)
        else $error("trip asleep");
    a_wake_up: assert property (s_wake |=> !sleep_period)
        else $error("no wake");
    a_sleep_stay: assert property (sleep_period && g[1] == g[0] |=> sleep_period)
        else $error("left sleep");
    a_rd_upper: assert property (reg_rd |=> reg_rdata[7:4] == 4'h0)
        else $error("upper bits set");
endmodule // hbgmc_sva
bind hbgmc_top hbgmc_sva i_sva (.sys_clk, .rst_n, .reg_rd, .over_current_guard, .reg_rdata,
    .short_circuit_guard, .over_temp_guard, .gate_out_0, .gate_out_1, .bridge_out_a_oe,
    .bridge_out_a, .bridge_out_b_oe, .bridge_out_b, .high_switch_a, .low_switch_a,
    .high_switch_b, .low_switch_b, .sleep_period, .protect_trip);
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench of the bridge gate control against a shadow model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    localparam int S = 20;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, run = 0, stall = 0, et;
    logic timer_pwm = 0, periodic_timer_output = 0, short_circuit_guard = 0, over_temp_guard = 0;
    logic over_current_guard, gate_out_0, gate_out_1, sleep_period, protect_trip;
    logic bridge_out_a, bridge_out_a_oe, bridge_out_b, bridge_out_b_oe;
    logic high_switch_a, low_switch_a, high_switch_b, low_switch_b;
    logic [1:0]  reg_addr = 2'h0, eg, pg;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, s_src, s_lvl, r;
    logic [31:0] seed = 32'h4A1DE597;
    int          err_total = 0, check_count = 0, n;
    wire logic [7:0] o = {bridge_out_a_oe, bridge_out_a_oe & bridge_out_a, bridge_out_b_oe,
        bridge_out_b_oe & bridge_out_b, high_switch_a, low_switch_a, high_switch_b, low_switch_b};
    always #20 sys_clk = ~sys_clk;
    hbgmc_top #(.SLEEP_CYCLES(S)) i_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .timer_pwm, .periodic_timer_output, .over_current_guard,
        .short_circuit_guard, .over_temp_guard, .gate_out_0, .gate_out_1, .bridge_out_a,
        .bridge_out_a_oe, .bridge_out_b, .bridge_out_b_oe, .high_switch_a, .low_switch_a,
        .high_switch_b, .low_switch_b, .sleep_period, .protect_trip);
    hbgmc_motor i_motor (.high_switch_a, .low_switch_a, .high_switch_b, .low_switch_b, .stall,
        .over_current_guard);
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [7:0] drv(input logic [1:0] m, input logic t);
        if (t) return 8'h00;
        case (m)
            2'h0: return 8'h00;
            2'h1: return 8'hB6;
            2'h2: return 8'hE9;
            default: return 8'hA5;
        endcase
    endfunction
    task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s exp %h got %h", w, e, s);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        @(negedge sys_clk) cmp("rdata", e, reg_rdata);
        @(posedge sys_clk);
    endtask
    task automatic give_verdict();
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Shadow registers and one-cycle pipeline of the expected gates, mode and trip.
    always @(posedge sys_clk) begin
        if (!rst_n) {s_src, s_lvl} <= 16'h0000;
        else if (reg_wr && reg_addr == 2'h0) s_src <= reg_wdata & 8'h0F;
        else if (reg_wr && reg_addr == 2'h1) s_lvl <= reg_wdata & 8'h0F;
        eg <= {s_src[1] ? s_lvl[1] : timer_pwm, s_src[3] ? s_lvl[3] : periodic_timer_output};
        pg <= eg;
        et <= (over_current_guard | short_circuit_guard | over_temp_guard) & !sleep_period;
    end
    always @(negedge sys_clk) if (run) begin
        cmp("gates", eg, gate_out_0 << 1 | gate_out_1);
        cmp("trip", et, protect_trip);
        cmp("bridge", drv(pg, et), o);
    end
    initial begin
        tick(20);
        {rst_n, run} <= 2'b11;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        r = rnd();
        wr(2'h3, r);
        rd(2'h3, 8'h00);
        wr(2'h0, r | 8'h05);
        rd(2'h0, (r | 8'h05) & 8'h0F);
        wr(2'h0, 8'h05);
        repeat (16) begin
            r = rnd();
            {timer_pwm, periodic_timer_output} <= r[1:0];
            tick(1);
        end
        wr(2'h0, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            wr(2'h1, {4'h0, i[1], 1'b1, i[0], 1'b1});
            tick(4);
        end
        wr(2'h1, 8'h07);
        repeat (12) begin
            r = rnd();
            {stall, short_circuit_guard, over_temp_guard} <= r[2:0];
            tick(2);
        end
        {stall, short_circuit_guard, over_temp_guard} <= 3'b000;
        wr(2'h1, 8'h0F);
        for (n = 0; sleep_period !== 1'b1 && n < 60; n++) @(negedge sys_clk);
        cmp("sleep_delay", 8'h01, n >= S + 2 && n <= S + 5);
        tick(1);
        wr(2'h1, 8'h05);
        short_circuit_guard <= 1'b1;
        tick(4);
        wr(2'h1, 8'h0F);
        tick(3);
        @(negedge sys_clk) cmp("sleep", 8'h01, sleep_period);
        tick(1);
        rd(2'h2, 8'h03);
        short_circuit_guard <= 1'b0;
        wr(2'h1, 8'h0D);
        tick(3);
        @(negedge sys_clk) cmp("sleep", 8'h00, sleep_period);
        give_verdict();
    end
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
